// ===== hdl/pls_buf2.sv
// small valid/ready word buffer between capture and serializer
`timescale 1ns/1ps
module pls_buf2 #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_q;

    wire push_w = in_valid && in_ready;
    wire pop_w  = out_valid && out_ready;
    wire [PW-1:0] wr_next_w = (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    wire [PW-1:0] rd_next_w = (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;

    assign in_ready  = (count_q != CW'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data  = mem_q[rd_ptr_q];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push_w) begin
                wr_ptr_q <= wr_next_w;
            end
            if (pop_w) begin
                rd_ptr_q <= rd_next_w;
            end
            if (push_w && !pop_w) begin
                count_q <= count_q + 1'b1;
            end else if (pop_w && !push_w) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    genvar e;
    generate
        for (e = 0; e < DEPTH; e++) begin : g_entry
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    mem_q[e] <= '0;
                end else if (push_w && wr_ptr_q == PW'(e)) begin
                    mem_q[e] <= in_data;
                end
            end
        end
    endgenerate

endmodule

// ===== hdl/pls_defines.svh
// pixel lane serializer constants: geometry, timing and output patterns
`ifndef PLS_DEFINES_SVH
`define PLS_DEFINES_SVH

// word and lane geometry
`define PLS_WORD_BITS      28
`define PLS_LANES          4
`define PLS_SLICE_BITS     7
`define PLS_SLICE_LAST     3'h6

// forwarded clock shape across one slice, first bit in the top position
`define PLS_FWD_CLK_PATTERN 7'h63

// system clock and the slowest and fastest pixel clocks the host may supply
`define PLS_SYS_CLK_MHZ    250
`define PLS_PIX_MIN_MHZ    10
`define PLS_PIX_MAX_MHZ    135
`define PLS_PIX_MAX_PERIOD_CYC ((`PLS_SYS_CLK_MHZ + `PLS_PIX_MIN_MHZ - 1) / `PLS_PIX_MIN_MHZ)

// pixel period measurement counter
`define PLS_PERIOD_BITS    8
`define PLS_PERIOD_RESET   8'h07

// two-entry word buffer
`define PLS_BUF_DEPTH      2

`endif

// ===== hdl/pls_pkg.sv
// pixel lane serializer types
package pls_pkg;

    typedef logic [27:0] pls_word_t;
    typedef logic [6:0]  pls_slice_t;

    typedef enum logic [0:0] {
        PLS_ST_IDLE  = 1'b0,
        PLS_ST_SHIFT = 1'b1
    } pls_state_t;

endpackage

// ===== hdl/pls_serializer.sv
// pixel lane serializer: edge capture, word buffer, 7x lane shifters
`timescale 1ns/1ps
`include "pls_defines.svh"

// Functional notes
// - capture all 28 pixel input bits once per pixel clock, on the selected edge
// - edge select high picks rising edge, low picks falling; host holds it static
// - four independent 7-bit shift registers, parallel loaded from their word share
// - bit rate is seven times pixel rate; one 7-bit slice per pixel period
// - four serial lanes plus forwarded clock leave on five differential pairs
// - forwarded clock runs at pixel clock rate, one period per slice
// - power-down low stops internal clocking and switches serial drivers off
// - power-down low asynchronously clears every internal register to zero, except period_q which loads PLS_PERIOD_RESET
// - all output pairs float while power-down is low
module pls_serializer
    import pls_pkg::*;
#(
    parameter int         LANES       = `PLS_LANES,
    parameter int         SLICE       = `PLS_SLICE_BITS,
    parameter int         BUF_DEPTH   = `PLS_BUF_DEPTH,
    parameter bit         MSB_FIRST   = 1'b1,
    parameter pls_slice_t FWD_PATTERN = `PLS_FWD_CLK_PATTERN
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // pixel side pins
    input  wire logic             pixel_clock_in,
    input  wire logic             capture_edge_select,
    input  wire logic             power_down_n,
    input  wire logic [27:0]      pixel_data_in,
    // serial side pins
    output logic      [LANES-1:0] lane_pos,
    output logic      [LANES-1:0] lane_neg,
    output logic                  forwarded_clock_pos,
    output logic                  forwarded_clock_neg,
    output logic                  output_enable,
    // status
    output logic                  capture_ready
);

    // ------------------------------------------------------------
    // internal reset
    // ------------------------------------------------------------

    // power-down clears everything at once, no clock needed
    wire clear_w = rst | ~power_down_n;

    // run only after power-down release has settled in our domain
    logic run_meta_q;
    logic run_q;
    // edge history is only valid a cycle after run, else a high pin looks like a rise
    logic armed_q;

    always_ff @(posedge clock or posedge clear_w) begin
        if (clear_w) begin
            run_meta_q <= 1'b0;
            run_q      <= 1'b0;
            armed_q    <= 1'b0;
        end else begin
            run_meta_q <= 1'b1;
            run_q      <= run_meta_q;
            armed_q    <= run_q;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------

    // clock, select and data share one two-flop synchroniser so they stay aligned
    logic [29:0] pins_sync;

    pls_sync #(
        .WIDTH (30)
    ) u_pin_sync (
        .clock    (clock),
        .rst      (clear_w),
        .async_in ({capture_edge_select, pixel_clock_in, pixel_data_in}),
        .sync_out (pins_sync)
    );

    wire       edge_sel_w = pins_sync[29];
    wire       pclk_w     = pins_sync[28];
    pls_word_t data_w;
    assign data_w = pins_sync[27:0];

    // ------------------------------------------------------------
    // edge detection and capture
    // ------------------------------------------------------------

    logic      pclk_d_q;
    pls_word_t data_d_q;

    always_ff @(posedge clock or posedge clear_w) begin
        if (clear_w) begin
            pclk_d_q <= 1'b0;
            data_d_q <= '0;
        end else begin
            pclk_d_q <= pclk_w;
            data_d_q <= data_w;
        end
    end

    wire rise_w = pclk_w & ~pclk_d_q;
    wire fall_w = ~pclk_w & pclk_d_q;
    // data_d_q is the last sample before the edge, where setup holds
    wire capture_w = armed_q & (edge_sel_w ? rise_w : fall_w);

    pls_word_t hold_q;

    always_ff @(posedge clock or posedge clear_w) begin
        if (clear_w) begin
            hold_q <= '0;
        end else if (capture_w) begin
            hold_q <= data_d_q;
        end
    end

    logic capture_strobe_q;

    always_ff @(posedge clock or posedge clear_w) begin
        if (clear_w) begin
            capture_strobe_q <= 1'b0;
        end else begin
            capture_strobe_q <= capture_w;
        end
    end

    // ------------------------------------------------------------
    // pixel period measurement
    // ------------------------------------------------------------

    // bit time is a seventh of the measured period; the remainder idles
    logic [`PLS_PERIOD_BITS-1:0] cyc_q;
    logic [`PLS_PERIOD_BITS-1:0] period_q;

    wire cyc_full_w = (cyc_q == {`PLS_PERIOD_BITS{1'b1}});

    always_ff @(posedge clock or posedge clear_w) begin
        if (clear_w) begin
            cyc_q    <= '0;
            period_q <= `PLS_PERIOD_RESET;
        end else if (capture_w) begin
            cyc_q    <= '0;
            period_q <= cyc_q + 1'b1;
        end else if (!cyc_full_w) begin
            cyc_q <= cyc_q + 1'b1;
        end
    end

    wire [`PLS_PERIOD_BITS-1:0] div_w = period_q / `PLS_PERIOD_BITS'(SLICE);
    wire [`PLS_PERIOD_BITS-1:0] bit_len_w = (div_w == '0) ? `PLS_PERIOD_BITS'(1) : div_w;

    // ------------------------------------------------------------
    // word buffer
    // ------------------------------------------------------------

    logic      buf_in_ready;
    logic      buf_out_valid;
    logic      load_w;
    pls_word_t buf_out_data;

    pls_buf2 #(
        .WIDTH (28),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clock     (clock),
        .rst       (clear_w),
        .in_valid  (capture_strobe_q),
        .in_ready  (buf_in_ready),
        .in_data   (hold_q),
        .out_valid (buf_out_valid),
        .out_ready (load_w),
        .out_data  (buf_out_data)
    );

    // ------------------------------------------------------------
    // slice sequencer
    // ------------------------------------------------------------

    pls_state_t                  state_q;
    pls_state_t                  state_d;
    logic [`PLS_PERIOD_BITS-1:0] tick_q;
    logic [2:0]                  bit_q;

    wire bit_end_w  = (tick_q == bit_len_w - 1'b1) || (tick_q >= bit_len_w);
    wire last_bit_w = (bit_q == `PLS_SLICE_LAST);
    wire shifting_w = (state_q == PLS_ST_SHIFT);
    wire advance_w  = shifting_w && bit_end_w;
    wire slice_end_w = advance_w && last_bit_w;

    // no pixel clock means no words, so the shifters stop with it
    assign load_w = run_q && buf_out_valid && (!shifting_w || slice_end_w);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PLS_ST_IDLE: begin
                if (load_w) begin
                    state_d = PLS_ST_SHIFT;
                end
            end
            PLS_ST_SHIFT: begin
                if (slice_end_w && !load_w) begin
                    state_d = PLS_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge clear_w) begin
        if (clear_w) begin
            state_q <= PLS_ST_IDLE;
            tick_q  <= '0;
            bit_q   <= '0;
        end else begin
            state_q <= state_d;
            if (load_w || advance_w) begin
                tick_q <= '0;
            end else if (shifting_w) begin
                tick_q <= tick_q + 1'b1;
            end
            if (load_w) begin
                bit_q <= '0;
            end else if (advance_w) begin
                bit_q <= bit_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // lane shift registers
    // ------------------------------------------------------------

    logic [LANES-1:0] lane_bit_w;
    logic [LANES-1:0] lane_pos_q;
    logic [LANES-1:0] lane_neg_q;

    genvar l;
    generate
        for (l = 0; l < LANES; l++) begin : g_lane
            pls_slice_t shreg_q;
            // lane l takes word bits [7l+6:7l]
            wire pls_slice_t share_w = buf_out_data[l*SLICE +: SLICE];

            always_ff @(posedge clock or posedge clear_w) begin
                if (clear_w) begin
                    shreg_q <= '0;
                end else if (load_w) begin
                    shreg_q <= share_w;
                end else if (advance_w) begin
                    shreg_q <= MSB_FIRST ? {shreg_q[5:0], 1'b0} : {1'b0, shreg_q[6:1]};
                end
            end

            assign lane_bit_w[l] = shifting_w & (MSB_FIRST ? shreg_q[6] : shreg_q[0]);
        end
    endgenerate

    // ------------------------------------------------------------
    // forwarded clock shaper
    // ------------------------------------------------------------

    // one pattern rotation per slice keeps it locked to the data
    pls_slice_t fwd_q;

    always_ff @(posedge clock or posedge clear_w) begin
        if (clear_w) begin
            fwd_q <= '0;
        end else if (load_w) begin
            fwd_q <= FWD_PATTERN;
        end else if (advance_w) begin
            fwd_q <= {fwd_q[5:0], fwd_q[6]};
        end
    end

    wire fwd_bit_w = shifting_w & fwd_q[6];

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------

    logic fwd_pos_q;
    logic fwd_neg_q;
    logic oe_q;
    logic cap_ready_q;

    always_ff @(posedge clock or posedge clear_w) begin
        if (clear_w) begin
            lane_pos_q  <= '0;
            lane_neg_q  <= '0;
            fwd_pos_q   <= 1'b0;
            fwd_neg_q   <= 1'b0;
            oe_q        <= 1'b0;
            cap_ready_q <= 1'b0;
        end else begin
            lane_pos_q  <= lane_bit_w;
            lane_neg_q  <= ~lane_bit_w;
            fwd_pos_q   <= fwd_bit_w;
            fwd_neg_q   <= ~fwd_bit_w;
            oe_q        <= run_q;
            cap_ready_q <= buf_in_ready;
        end
    end

    assign lane_pos            = lane_pos_q;
    assign lane_neg            = lane_neg_q;
    assign forwarded_clock_pos = fwd_pos_q;
    assign forwarded_clock_neg = fwd_neg_q;
    assign output_enable       = oe_q;
    assign capture_ready       = cap_ready_q;

endmodule

// ===== hdl/pls_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module pls_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // meta_q is read by sync_q only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

// ===== verification/pls_rx_model.sv
// receiver model: rebuilds pixel words from the lanes and forwarded clock
`timescale 1ns/1ps
`include "pls_defines.svh"
module pls_rx_model
    import pls_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // serial side
    input  wire logic [3:0] lane_pos,
    input  wire logic       fwd_pos,
    input  wire logic       output_enable,
    // recovered word
    output logic            rx_valid,
    output pls_word_t       rx_word
);
    pls_slice_t clk_q;
    pls_slice_t clk_d;
    pls_word_t  shift_q;
    pls_word_t  shift_d;

    // floating pairs read as zero, so no slice can form while disabled
    always_comb begin
        clk_d = {clk_q[5:0], fwd_pos & output_enable};
        for (int l = 0; l < 4; l++) begin
            shift_d[7*l +: 7] = {shift_q[7*l +: 6], lane_pos[l] & output_enable};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clk_q    <= 7'h00;
            shift_q  <= 28'h0000000;
            rx_valid <= 1'b0;
            rx_word  <= 28'h0000000;
        end else begin
            clk_q    <= clk_d;
            shift_q  <= shift_d;
            rx_valid <= (clk_d == `PLS_FWD_CLK_PATTERN);
            rx_word  <= shift_d;
        end
    end
endmodule

// ===== verification/pls_serializer_asserts.sv
// assertions on the pixel lane serializer pins
`timescale 1ns/1ps
module pls_serializer_asserts #(
    parameter int LANES = 4
) (
    // clock and reset
    input wire logic             clock,
    input wire logic             rst,
    // pixel side
    input wire logic             pixel_clock_in,
    input wire logic             power_down_n,
    // serial side
    input wire logic [LANES-1:0] lane_pos,
    input wire logic [LANES-1:0] lane_neg,
    input wire logic             forwarded_clock_pos,
    input wire logic             forwarded_clock_neg,
    input wire logic             output_enable,
    input wire logic             capture_ready
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_wake;
        $rose(power_down_n);
    endsequence
    sequence s_awake;
        s_wake ##1 power_down_n [*8];
    endsequence

    property p_lane_diff;
        output_enable |-> lane_neg == ~lane_pos;
    endproperty
    a_lane_diff: assert property (p_lane_diff)
        else $error("lane pair not complementary");
    property p_fwd_diff;
        output_enable |-> forwarded_clock_neg == ~forwarded_clock_pos;
    endproperty
    a_fwd_diff: assert property (p_fwd_diff)
        else $error("clock pair not complementary");
    property p_down_off;
        !power_down_n |-> !output_enable && lane_pos == '0 && lane_neg == '0
            && !forwarded_clock_pos;
    endproperty
    a_down_off: assert property (p_down_off)
        else $error("outputs active in power down");
    property p_down_ready;
        !power_down_n |-> !capture_ready;
    endproperty
    a_down_ready: assert property (p_down_ready)
        else $error("ready set in power down");
    property p_wake_clear;
        s_wake |-> (lane_pos == '0 && !forwarded_clock_pos) [*3];
    endproperty
    a_wake_clear: assert property (p_wake_clear)
        else $error("stale data after power up");
    property p_wake_drive;
        s_awake |-> output_enable;
    endproperty
    a_wake_drive: assert property (p_wake_drive)
        else $error("drivers still off after power up");
    property p_wake_ready;
        s_wake |-> ##[1:2] capture_ready;
    endproperty
    a_wake_ready: assert property (p_wake_ready)
        else $error("ready late after power up");
    property p_fwd_follow;
        disable iff (rst || !power_down_n)
        output_enable && $rose(pixel_clock_in) |-> ##[1:60] $rose(forwarded_clock_pos);
    endproperty
    a_fwd_follow: assert property (p_fwd_follow)
        else $error("no forwarded clock after pixel edge");
endmodule

bind pls_serializer pls_serializer_asserts #(.LANES(LANES)) u_asserts (
    .clock(clock), .rst(rst), .pixel_clock_in(pixel_clock_in),
    .power_down_n(power_down_n), .lane_pos(lane_pos), .lane_neg(lane_neg),
    .forwarded_clock_pos(forwarded_clock_pos), .forwarded_clock_neg(forwarded_clock_neg),
    .output_enable(output_enable), .capture_ready(capture_ready)
);

// ===== verification/tb_pixel_lane_serializer.sv
// self-checking bench for the pixel lane serializer
`timescale 1ns/1ps
`define CHECK(got, exp, msg) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("unexpected at %0t ns: %s", $time, msg); \
    end \
end
module tb_pixel_lane_serializer
    import pls_pkg::*;
;
    logic       clock;
    logic       rst;
    logic       pixel_clock_in;
    logic       capture_edge_select;
    logic       power_down_n;
    pls_word_t  pixel_data_in;
    logic [3:0] lane_pos;
    logic [3:0] lane_neg;
    logic       fwd_pos;
    logic       fwd_neg;
    logic       output_enable;
    logic       capture_ready;
    logic       rx_valid;
    pls_word_t  rx_word;
    pls_word_t  got[$];
    int         fail_count;
    int         total_checks;

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // free running and off phase from the system clock
    initial begin
        pixel_clock_in = 1'b0;
        #1.3;
        forever #16 pixel_clock_in = ~pixel_clock_in;
    end

    pls_serializer DUT (
        .clock(clock), .rst(rst), .pixel_clock_in(pixel_clock_in),
        .capture_edge_select(capture_edge_select), .power_down_n(power_down_n),
        .pixel_data_in(pixel_data_in), .lane_pos(lane_pos), .lane_neg(lane_neg),
        .forwarded_clock_pos(fwd_pos), .forwarded_clock_neg(fwd_neg),
        .output_enable(output_enable), .capture_ready(capture_ready)
    );
    pls_rx_model u_rx (
        .clock(clock), .rst(rst), .lane_pos(lane_pos), .fwd_pos(fwd_pos),
        .output_enable(output_enable), .rx_valid(rx_valid), .rx_word(rx_word)
    );

    // the zero word is the filler between pulses, so it is not collected
    always @(posedge clock) begin
        if (rx_valid === 1'b1 && rx_word !== 28'h0000000) begin
            got.push_back(rx_word);
        end
    end

    task automatic test_done();
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic pix_edge(input logic rising);
        if (rising) @(posedge pixel_clock_in);
        else @(negedge pixel_clock_in);
    endtask

    // word stands only around the selected edge: the other edge sees zero
    task automatic send_pulse(input pls_word_t w);
        pix_edge(~capture_edge_select);
        repeat (2) @(posedge clock);
        pixel_data_in <= w;
        pix_edge(capture_edge_select);
        repeat (2) @(posedge clock);
        pixel_data_in <= 28'h0000000;
    endtask

    task automatic stream_check(input pls_word_t w[$]);
        int n;
        got.delete();
        foreach (w[i]) send_pulse(w[i]);
        n = 0;
        while (got.size() < w.size() && n < 200) begin
            @(posedge clock);
            n++;
        end
        repeat (20) @(posedge clock);
        `CHECK(got.size(), w.size(), "word count")
        foreach (w[i]) begin
            if (i < got.size()) `CHECK(got[i], w[i], "word on lanes")
        end
    endtask

    task automatic test_reset(input logic sel);
        rst <= 1'b1;
        capture_edge_select <= sel;
        repeat (3) @(posedge clock);
        `CHECK(output_enable, 1'b0, "enable in reset")
        `CHECK(capture_ready, 1'b0, "ready in reset")
        `CHECK(lane_pos, 4'h0, "lanes in reset")
        rst <= 1'b0;
        repeat (6) @(posedge clock);
        `CHECK(output_enable, 1'b1, "enable after reset")
        `CHECK(capture_ready, 1'b1, "ready after reset")
    endtask

    task automatic test_rising();
        stream_check('{28'h0000001, 28'h8000000, 28'hfffffff, 28'h5555555,
                       28'haaaaaaa, 28'h1234567});
    endtask

    // a word sent just before power down, cleared before it is captured, must never reach the lanes
    task automatic test_power_down();
        got.delete();
        send_pulse(28'hc3c3c3c);
        power_down_n <= 1'b0;
        repeat (2) @(posedge clock);
        `CHECK(output_enable, 1'b0, "enable in power down")
        `CHECK({lane_pos, fwd_pos}, 5'h00, "lanes in power down")
        `CHECK(capture_ready, 1'b0, "ready in power down")
        repeat (10) @(posedge clock);
        power_down_n <= 1'b1;
        repeat (8) @(posedge clock);
        `CHECK(got.size(), 0, "word leaked across power down")
        stream_check('{28'h0a5a5a5});
    endtask

    // last word has the seven 18-bit colour spare inputs tied low
    task automatic test_falling();
        stream_check('{28'h7654321, 28'h0000080, 28'hc0ffee1, 28'h77cf3df});
    endtask

    initial begin
        #20000;
        fail_count++;
        $display("unexpected at %0t ns: watchdog expired", $time);
        test_done();
    end

    initial begin
        rst = 1'b1;
        power_down_n = 1'b1;
        capture_edge_select = 1'b1;
        pixel_data_in = 28'h0000000;
        fail_count = 0;
        total_checks = 0;
        test_reset(1'b1);
        test_rising();
        test_power_down();
        test_reset(1'b0);
        test_falling();
        test_done();
    end
endmodule
